// File: hdl/clock_select_defines.vh
// What this block does
// [RULE_01] Processor source bit: 0 internal oscillator, 1 external input.
// [RULE_02] Selected processor source divided by two to the power 0-5 or 7.
// [RULE_03] USB source bit: 0 internal oscillator, 1 external clock.
// [RULE_04] USB divide-disable clear halves; internal source always halved.
// [RULE_05] Software sets undivided USB only with a 12 MHz external clock.
// [RULE_06] Traffic trimming only when internal oscillator sources USB clock.
// [RULE_07] Interval timer clock from four sources, prescaled by 1, 2, 3 or 4.
// [RULE_08] Capture timer clock from external, internal 24 MHz or 32 kHz.
// [RULE_09] Output pin: filtered input, 24 MHz, 32 kHz or processor clock.
// [RULE_10] 32 kHz clock runs wakeup and power sequencing with main clock off.
// [RULE_11] Software reads interval counter twice until two reads agree.
// [RULE_12] Fine offset bits add 7.5, 15 and 30 kHz; factory leaves zero.
// [RULE_13] Five gain bits scale offset step; lower gain gives larger steps.
// [RULE_14] Calibration fields undefined at reset; boot loads factory values.
// [RULE_15] Low-power trim bit 7: 0 normal mode, 1 low-power mode.
// [RULE_16] Software changes low-power bit by read-modify-write, keeping trims.
// [RULE_17] Bias code 00 mid, 01 high; software never writes reserved 10.
// [RULE_18] Four-bit frequency trim adjusts the 32 kHz oscillator.
// [RULE_19] Divider codes 000-110 give 8,4,2,1,16,32,128; 111 reserved.
// [RULE_20] Reserved bits read zero; writes to them have no effect.
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH
// Offsets are word indices; the bus byte address is four times the index
`define IDX_CPU_USB_CLOCK_CONFIG 10'h030
`define IDX_MAIN_OSCILLATOR_TRIM 10'h034
`define IDX_SLOW_OSCILLATOR_TRIM 10'h036
`define IDX_CLOCK_ROUTING 10'h038
`define IDX_CLOCK_STATUS 10'h03C
`define ADDR_CPU_USB_CLOCK_CONFIG {`IDX_CPU_USB_CLOCK_CONFIG, 2'h0}
`define ADDR_MAIN_OSCILLATOR_TRIM {`IDX_MAIN_OSCILLATOR_TRIM, 2'h0}
`define ADDR_SLOW_OSCILLATOR_TRIM {`IDX_SLOW_OSCILLATOR_TRIM, 2'h0}
`define ADDR_CLOCK_ROUTING {`IDX_CLOCK_ROUTING, 2'h0}
`define ADDR_CLOCK_STATUS {`IDX_CLOCK_STATUS, 2'h0}
`define CFG_CPU_SRC_BIT 0
`define CFG_USB_SRC_BIT 5
`define CFG_USB_NODIV_BIT 6
`define CFG_WRITE_MASK 8'h61
`define CFG_RESET 8'h00
`define MAIN_TRIM_WRITE_MASK 8'hFF
`define MAIN_TRIM_RESET 8'h00
`define SLOW_TRIM_WRITE_MASK 8'hBF
`define SLOW_TRIM_RESET 8'h00
`define SLOW_LP_BIT 7
`define ROUTE_WRITE_MASK 32'h0003FFF7
`define ROUTE_RESET 32'h00000000
`define DIV_CODE_RESERVED 3'h7
`define SRC_INTERNAL 2'h0
`define SRC_EXTERNAL 2'h1
`define SRC_SLOW 2'h2
`define SRC_CAPTURE 2'h3
`endif

// File: hdl/clock_divider.v
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// Divide an enable strobe by N
// -----------------------------
module clock_divider #(
  parameter WIDTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire tick_in,
  input wire [WIDTH-1:0] ratio,
  output reg tick_out
);
  reg [WIDTH-1:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= ratio) begin
          count <= {WIDTH{1'b0}};
          tick_out <= 1'b1;
        end else begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // clock_divider
`default_nettype wire

// File: hdl/oscillator_clock_selection.v
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defines.vh"
// -----------------------------
// Clock selection and trim
// -----------------------------
// Clocks are modelled as one-cycle enable ticks on pclk; a real clock tree
// would use glitch-free muxes, which are beyond a register model.
module oscillator_clock_selection (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire internal_tick,
  input wire external_tick,
  input wire slow_tick,
  input wire usb_traffic,
  input wire main_clock_stopped,
  output reg processor_clock,
  output reg usb_engine_clock,
  output reg interval_timer_clock,
  output reg capture_timer_clock,
  output reg clock_output_pin,
  output reg traffic_trim_enable,
  output reg sequencing_clock,
  output reg [7:0] main_trim,
  output reg [7:0] slow_trim
);
  // -----------------------------
  // Registers
  // -----------------------------
  reg [7:0] cpu_usb_clock_config;
  reg [31:0] clock_routing;
  reg transient_filter_q;
  wire [2:0] cpu_div_code = clock_routing[2:0];
  wire [1:0] interval_sel = clock_routing[5:4];
  wire [1:0] interval_div = clock_routing[7:6];
  wire [1:0] capture_sel = clock_routing[9:8];
  wire [1:0] out_sel = clock_routing[11:10];
  wire filter_enable = clock_routing[12];
  wire [31:0] route_mask = `ROUTE_WRITE_MASK;

  function [7:0] cpu_ratio;
    input [2:0] code;
    begin
      case (code) // [RULE_19]
        3'h0: cpu_ratio = 8'h08;
        3'h1: cpu_ratio = 8'h04;
        3'h2: cpu_ratio = 8'h02;
        3'h3: cpu_ratio = 8'h01;
        3'h4: cpu_ratio = 8'h10;
        3'h5: cpu_ratio = 8'h20;
        3'h6: cpu_ratio = 8'h80; // [RULE_02]
        default: cpu_ratio = 8'h08;
      endcase
    end
  endfunction

  function pick;
    input [1:0] sel;
    input a;
    input b;
    input c;
    input d;
    begin
      case (sel)
        2'h0: pick = a;
        2'h1: pick = b;
        2'h2: pick = c;
        default: pick = d;
      endcase
    end
  endfunction

  // -----------------------------
  // APB slave, zero wait states
  // -----------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire mapped = (paddr == `ADDR_CPU_USB_CLOCK_CONFIG) ||
                (paddr == `ADDR_MAIN_OSCILLATOR_TRIM) ||
                (paddr == `ADDR_SLOW_OSCILLATOR_TRIM) ||
                (paddr == `ADDR_CLOCK_ROUTING) ||
                (paddr == `ADDR_CLOCK_STATUS);
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `ADDR_CPU_USB_CLOCK_CONFIG:
        next_prdata = {24'h000000, cpu_usb_clock_config};
      `ADDR_MAIN_OSCILLATOR_TRIM:
        next_prdata = {24'h000000, main_trim};
      `ADDR_SLOW_OSCILLATOR_TRIM:
        next_prdata = {24'h000000, slow_trim};
      `ADDR_CLOCK_ROUTING: next_prdata = clock_routing;
      `ADDR_CLOCK_STATUS: next_prdata = {27'h0000000, sequencing_clock,
        traffic_trim_enable, capture_timer_clock, interval_timer_clock,
        processor_clock};
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_usb_clock_config <= `CFG_RESET;
      main_trim <= `MAIN_TRIM_RESET; // [RULE_14]
      slow_trim <= `SLOW_TRIM_RESET;
      clock_routing <= `ROUTE_RESET;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
        prdata <= next_prdata;
      if (wr && pready && mapped) begin
        if (paddr == `ADDR_CPU_USB_CLOCK_CONFIG)
          cpu_usb_clock_config <= pwdata[7:0] & `CFG_WRITE_MASK; // [RULE_20]
        if (paddr == `ADDR_MAIN_OSCILLATOR_TRIM) // [RULE_13]
          main_trim <= pwdata[7:0] & `MAIN_TRIM_WRITE_MASK; // [RULE_12]
        if (paddr == `ADDR_SLOW_OSCILLATOR_TRIM) // [RULE_18]
          slow_trim <= pwdata[7:0] & `SLOW_TRIM_WRITE_MASK; // [RULE_15]
        if (paddr == `ADDR_CLOCK_ROUTING) begin
          clock_routing[31:3] <= pwdata[31:3] & route_mask[31:3];
          if (pwdata[2:0] != `DIV_CODE_RESERVED)
            clock_routing[2:0] <= pwdata[2:0]; // [RULE_19]
        end
      end
    end
  end

  // -----------------------------
  // Source selection
  // -----------------------------
  wire cpu_src = cpu_usb_clock_config[`CFG_CPU_SRC_BIT] ?
    external_tick : internal_tick; // [RULE_01]
  wire usb_ext = cpu_usb_clock_config[`CFG_USB_SRC_BIT]; // [RULE_03]
  wire usb_src = usb_ext ? external_tick : internal_tick;
  // Internal path always halved; external halved unless disabled
  wire [1:0] usb_ratio = (usb_ext && cpu_usb_clock_config[`CFG_USB_NODIV_BIT])
    ? 2'h1 : 2'h2; // [RULE_04]
  wire capture_src = pick(capture_sel, internal_tick, external_tick,
    slow_tick, 1'b0); // [RULE_08]
  wire interval_src = pick(interval_sel, internal_tick, external_tick,
    slow_tick, capture_timer_clock); // [RULE_07]
  wire cpu_tick;
  wire usb_tick;
  wire interval_tick;

  clock_divider #(.WIDTH(8)) cpu_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(cpu_src),
    .ratio(cpu_ratio(cpu_div_code)),
    .tick_out(cpu_tick)
  );
  clock_divider #(.WIDTH(2)) usb_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(usb_src),
    .ratio(usb_ratio),
    .tick_out(usb_tick)
  );
  clock_divider #(.WIDTH(3)) interval_div_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(interval_src),
    .ratio({1'b0, interval_div} + 3'h1), // [RULE_07]
    .tick_out(interval_tick)
  );

  // -----------------------------
  // Outputs
  // -----------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_clock <= 1'b0;
      usb_engine_clock <= 1'b0;
      interval_timer_clock <= 1'b0;
      capture_timer_clock <= 1'b0;
      clock_output_pin <= 1'b0;
      traffic_trim_enable <= 1'b0;
      sequencing_clock <= 1'b0;
      transient_filter_q <= 1'b0;
    end else begin
      processor_clock <= cpu_tick;
      usb_engine_clock <= usb_tick;
      interval_timer_clock <= interval_tick;
      capture_timer_clock <= capture_src;
      // Filter drops one-cycle glitches at the cost of one cycle of lag
      transient_filter_q <= external_tick;
      clock_output_pin <= pick(out_sel,
        filter_enable ? (transient_filter_q & external_tick) : external_tick,
        internal_tick, slow_tick, cpu_tick); // [RULE_09]
      traffic_trim_enable <= !usb_ext && usb_traffic; // [RULE_06]
      sequencing_clock <= main_clock_stopped & slow_tick; // [RULE_10]
    end
  end
endmodule // oscillator_clock_selection
`default_nettype wire

// File: tb/oscillator_clock_selection_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------
// Port checker
// ------------
module clock_select_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire internal_tick,
  input wire external_tick,
  input wire slow_tick,
  input wire usb_traffic,
  input wire processor_clock,
  input wire usb_engine_clock,
  input wire capture_timer_clock,
  input wire traffic_trim_enable,
  input wire sequencing_clock,
  input wire [7:0] main_trim,
  input wire [7:0] slow_trim
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire mapped = paddr inside {12'h0C0, 12'h0D0, 12'h0D8, 12'h0E0, 12'h0F0};
  reg [7:0] cfg;
  // Shadow of the source selects, kept from bus writes alone
  always @(posedge pclk or negedge presetn)
    if (!presetn) cfg <= 8'h00;
    else if (wr && paddr == 12'h0C0) cfg <= pwdata[7:0];
  // Divider flop and output flop each add a cycle: sources are two back
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  bad_addr_a: assert property (acc |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  cpu_source_a: assert property (processor_clock |->
    $past(cfg[0] ? external_tick : internal_tick, 2))
    else $error("processor pulse without selected source");
  usb_source_a: assert property (usb_engine_clock |->
    $past(cfg[5] ? external_tick : internal_tick, 2))
    else $error("usb pulse without selected source");
  usb_half_a: assert property (usb_engine_clock && !cfg[5] && !wr
    |=> !usb_engine_clock) else $error("internal usb path not halved");
  trim_follow_a: assert property ($past(presetn) |->
    traffic_trim_enable == $past(!cfg[5] && usb_traffic))
    else $error("traffic trim enable wrong");
  cap_source_a: assert property (capture_timer_clock |->
    $past(internal_tick || external_tick || slow_tick))
    else $error("capture pulse without source");
  seq_slow_a: assert property (sequencing_clock
    |-> $past(slow_tick))
    else $error("sequencing pulse without slow tick");
  main_trim_a: assert property (wr && paddr == 12'h0D0 |=>
    main_trim == $past(pwdata[7:0])) else $error("main trim not loaded");
  slow_trim_a: assert property (wr && paddr == 12'h0D8 |=>
    slow_trim == ($past(pwdata[7:0]) & 8'hBF))
    else $error("slow trim not loaded");
  cover property (wr);
  cover property (acc && pslverr);
  cover property (processor_clock && cfg[0]);
endmodule // clock_select_sva
bind oscillator_clock_selection clock_select_sva clock_select_sva_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .internal_tick, .external_tick, .slow_tick, .usb_traffic,
  .processor_clock, .usb_engine_clock, .capture_timer_clock,
  .traffic_trim_enable, .sequencing_clock, .main_trim, .slow_trim);
`default_nettype wire

// File: tb/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------
// External clock source
// ---------------------
module ext_clock_source #(parameter PERIOD = 4) (
  input wire pclk,
  input wire run,
  output logic tick
);
  int n = 0;
  initial tick = 1'b0;
  // Still outside bursts; a fixed rate keeps undivided USB legal
  always @(posedge pclk) begin
    n <= run ? (n + 1) % PERIOD : 0;
    tick <= run && n == PERIOD - 1;
  end
endmodule // ext_clock_source
`default_nettype wire

// File: tb/oscillator_clock_selection_bench.sv
`timescale 1ns/1ps
`default_nettype none
module oscillator_clock_selection_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, internal_tick = 1'b0, slow_tick = 1'b0;
  logic usb_traffic = 1'b0, stopped = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire external_tick, pready, pslverr, processor_clock;
  wire interval_timer_clock, clock_output_pin;
  wire [31:0] prdata;
  logic [32:0] exq[$];
  logic [7:0] v;
  int miscompares = 0, n_checks = 0, cyc = 0, pulses = 0, p0;
  int ipulses = 0, opulses = 0, i0, o0;
  int codes[8] = '{3, 2, 1, 0, 4, 5, 6, 3};
  int ratio[8] = '{1, 2, 4, 8, 16, 32, 128, 4};
  always #2.5 pclk = ~pclk;
  ext_clock_source ext_clock_source_inst (.pclk, .run, .tick(external_tick));
  oscillator_clock_selection oscillator_clock_selection_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .internal_tick, .external_tick, .slow_tick,
    .usb_traffic, .main_clock_stopped(stopped), .processor_clock,
    .usb_engine_clock(), .interval_timer_clock, .capture_timer_clock(),
    .clock_output_pin, .traffic_trim_enable(), .sequencing_clock(),
    .main_trim(), .slow_trim());
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got[32] !== exp[32] || (!exp[32] && got[31:0] !== exp[31:0])) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after an edge; reads note their expectation at setup.
  // One idle cycle follows, so psel is never lowered and raised at once.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exq.pop_front());
  always @(posedge pclk) if (processor_clock) pulses++;
  always @(posedge pclk) if (interval_timer_clock) ipulses++;
  always @(posedge pclk) if (clock_output_pin) opulses++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    void'($urandom(40));
    forever @(posedge pclk) begin
      slow_tick <= 1'($urandom);
      usb_traffic <= 1'($urandom);
      stopped <= 1'($urandom);
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    internal_tick <= 1'b1;
    @(posedge pclk);
    xfer(0, 12'h0C0, 32'h0, 33'h0);
    xfer(0, 12'h0C0, 32'h0, 33'h0);
    xfer(0, 12'h0E0, 32'h0, 33'h0);
    xfer(1, 12'h0C0, 32'hFFFFFFFF, 33'h0);
    xfer(0, 12'h0C0, 32'h0, 33'h61);
    xfer(1, 12'h0C0, 32'h0, 33'h0);
    v = 8'($urandom);
    xfer(1, 12'h0D0, {24'h0, v}, 33'h0);
    xfer(0, 12'h0D0, 32'h0, 33'(v));
    v = 8'($urandom) & 8'h9F;
    xfer(1, 12'h0D8, {24'h0, v}, 33'h0);
    xfer(1, 12'h0D8, {24'h0, v | 8'h80}, 33'h0);
    xfer(0, 12'h0D8, 32'h0, 33'(v | 8'h80));
    xfer(0, 12'h040, 32'h0, 33'h100000000);
    xfer(1, 12'h0E0, 32'h3, 33'h0);
    xfer(1, 12'h0E0, 32'hFFFFFFFF, 33'h0);
    xfer(0, 12'h0E0, 32'h0, 33'h3FFF3);
    // Ratios grow except on the last pass; a divider above its new ratio restarts on its next tick.
    // A window of 384 cycles holds a whole number of every period used.
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (i == 7) begin
        run <= 1'b1;
        xfer(1, 12'h0C0, 32'h1, 33'h0);
      end
      // Output pin: external on the last pass, internal before, else cpu
      xfer(1, 12'h0E0, 32'(codes[i] + 64 * (i % 4) +
           1024 * (i == 7 ? 0 : i == 6 ? 1 : 3)), 33'h0);
      repeat (130) @(posedge pclk);
      @(negedge pclk);
      p0 = pulses;
      i0 = ipulses;
      o0 = opulses;
      repeat (384) @(negedge pclk);
      chk({1'b0, 32'(pulses - p0)}, 33'(384 / ratio[i]));
      chk({1'b0, 32'(ipulses - i0)}, 33'(384 / (i % 4 + 1)));
      chk({1'b0, 32'(opulses - o0)},
          33'(i == 6 ? 384 : 384 / ratio[i]));
    end
    results();
  end
endmodule // oscillator_clock_selection_bench
`default_nettype wire
